// file: pkg/cmbt_pkg.sv
package cmbt_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [3:0] CMBT_OFF_MODE_CONTROL = 4'h0;
  localparam logic [3:0] CMBT_OFF_MAIN_CONTROL = 4'h1;
  localparam logic [3:0] CMBT_OFF_BIT_TIMING_ZERO = 4'h2;

  // Mode control fields.
  localparam int CMBT_MODE_INIT_REQUEST = 0;
  localparam int CMBT_MODE_SLEEP_REQUEST = 1;
  localparam int CMBT_MODE_WAKE_ENABLE = 2;
  localparam int CMBT_MODE_BUSOFF_RECOVER = 3;

  // Main control fields.
  localparam int CMBT_MAIN_INIT_ACK = 0;
  localparam int CMBT_MAIN_SLEEP_ACK = 1;
  localparam logic [7:0] CMBT_MAIN_RESET = 8'h00;
  localparam logic [7:0] CMBT_BTR0_RESET = 8'h00;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CMBT_CLK_PERIOD_PS = 4000;
  localparam int CMBT_WAKE_PULSE_TIME_NS = 2000;
  localparam int CMBT_WAKE_PULSE_CYC =
    (CMBT_WAKE_PULSE_TIME_NS * 1000 + CMBT_CLK_PERIOD_PS - 1) / CMBT_CLK_PERIOD_PS;
  localparam logic [11:0] CMBT_WAKE_PULSE_CYC_W = 12'(CMBT_WAKE_PULSE_CYC);

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef struct packed {
    logic module_enable;
    logic protocol_clock_select;
    logic internal_loopback;
    logic listen_only;
    logic busoff_recovery_select;
    logic wake_filter_select;
    logic sleep_ack;
    logic init_ack;
  } cmbt_main_t;

  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [5:0] quantum_prescaler;
  } cmbt_btr0_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cmbt_bus_t;

  typedef enum logic [2:0] {
    CMBT_ST_RUN = 3'b001,
    CMBT_ST_INIT = 3'b010,
    CMBT_ST_SLEEP = 3'b100
  } cmbt_state_t;

endpackage

// file: design/cmbt_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Enable bit written once, except special mode
// - Enable bit zero disables the module
// - Clock select: oscillator or bus clock
// - Loopback feeds transmitter back to receiver
// - Listen-only receives, never drives the bus
// - Listen-only freezes the error counters
// - Listen-only blocks starting any transmission
// - Bus-off recovery automatic or on request
// - Wake filter: any dominant or long pulse
// - Sleep ack set on entry, cleared on wake
// - Clearing sleep request clears sleep ack
// - Init ack reports initialization mode
// - Configuration writes only in init mode
// - Bit timing readable always, written in init
// - Jump width is code plus one quanta
// - Prescaler divides by field plus one
// - Sleep entered only when bus idle
// - Init request aborts traffic, then acknowledges
module cmbt_ctrl
  import cmbt_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // System mode.
  input wire logic special_mode_i,
  // Protocol clock ticks.
  input wire logic osc_tick_i,
  input wire logic bus_tick_i,
  // Protocol core.
  input wire logic core_tx_bit_i,
  input wire logic core_rx_busy_i,
  input wire logic core_tx_pending_i,
  input wire logic core_busoff_i,
  output logic core_rx_bit_o,
  output logic core_abort_o,
  output logic core_tx_start_allow_o,
  output logic core_err_hold_o,
  output logic core_busoff_auto_o,
  output logic core_busoff_recover_o,
  output logic module_enable_o,
  output logic protocol_clock_select_o,
  output logic tq_tick_o,
  output logic [2:0] resync_jump_width_o,
  output logic [6:0] prescale_factor_o,
  output logic init_ack_o,
  output logic sleep_ack_o,
  // Bus pins.
  input wire logic can_rx_i,
  output logic can_tx_o
);

  // ****************************************************************
  // Decoding.
  // ****************************************************************
  function automatic logic hit(input cmbt_bus_t b, input logic [3:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  cmbt_bus_t bus;
  cmbt_main_t wmain;
  cmbt_state_t state_reg;
  cmbt_state_t state_next;
  cmbt_main_t main_reg;
  cmbt_btr0_t btr0_reg;
  logic init_request_reg;
  logic sleep_request_reg;
  logic wake_enable_reg;
  logic enable_written_reg;
  logic recover_req_reg;
  logic init_active;
  logic sleep_active;
  logic wake_event;
  logic [2:0] rx_sync_reg;
  logic rx_level_reg;
  logic [11:0] wake_cnt_reg;
  logic [5:0] tq_cnt_reg;
  logic tq_tick_reg;
  logic proto_tick;
  logic [7:0] rdata_reg;

  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign wmain = bus.wdata;
  assign init_active = init_request_reg && (state_reg == CMBT_ST_INIT);
  assign sleep_active = sleep_request_reg && (state_reg == CMBT_ST_SLEEP);

  // ****************************************************************
  // Mode state machine.
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CMBT_ST_RUN: begin
        if (init_request_reg) begin
          state_next = CMBT_ST_INIT;
        end else if (sleep_request_reg && !core_rx_busy_i && !core_tx_pending_i) begin
          state_next = CMBT_ST_SLEEP;
        end
      end
      CMBT_ST_SLEEP: begin
        if (init_request_reg) begin
          state_next = CMBT_ST_INIT;
        end else if (!sleep_request_reg || wake_event) begin
          state_next = CMBT_ST_RUN;
        end
      end
      CMBT_ST_INIT: begin
        if (!init_request_reg) begin
          state_next = CMBT_ST_RUN;
        end
      end
      default: begin
        state_next = CMBT_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_reg <= CMBT_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Mode requests.
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      init_request_reg <= 1'b0;
      sleep_request_reg <= 1'b0;
      wake_enable_reg <= 1'b0;
    end else begin
      if (hit(bus, CMBT_OFF_MODE_CONTROL)) begin
        wake_enable_reg <= bus.wdata[CMBT_MODE_WAKE_ENABLE];
        if (bus.wdata[CMBT_MODE_INIT_REQUEST] || init_active) begin
          init_request_reg <= bus.wdata[CMBT_MODE_INIT_REQUEST];
        end
        if (bus.wdata[CMBT_MODE_SLEEP_REQUEST] || sleep_active) begin
          sleep_request_reg <= bus.wdata[CMBT_MODE_SLEEP_REQUEST];
        end
      end
      if (wake_event) begin
        sleep_request_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      recover_req_reg <= 1'b0;
    end else begin
      recover_req_reg <= hit(bus, CMBT_OFF_MODE_CONTROL) && bus.wdata[CMBT_MODE_BUSOFF_RECOVER];
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      main_reg <= CMBT_MAIN_RESET;
      enable_written_reg <= 1'b0;
    end else if (hit(bus, CMBT_OFF_MAIN_CONTROL) && init_active) begin
      main_reg.protocol_clock_select <= wmain.protocol_clock_select;
      main_reg.internal_loopback <= wmain.internal_loopback;
      main_reg.listen_only <= wmain.listen_only;
      main_reg.busoff_recovery_select <= wmain.busoff_recovery_select;
      main_reg.wake_filter_select <= wmain.wake_filter_select;
      if (!enable_written_reg || special_mode_i) begin
        main_reg.module_enable <= wmain.module_enable;
        enable_written_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      btr0_reg <= CMBT_BTR0_RESET;
    end else if (hit(bus, CMBT_OFF_BIT_TIMING_ZERO) && init_active) begin
      btr0_reg <= bus.wdata;
    end
  end

  // ****************************************************************
  // Register reads.
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        CMBT_OFF_MODE_CONTROL: begin
          rdata_reg <= {5'h00, wake_enable_reg, sleep_request_reg, init_request_reg};
        end
        CMBT_OFF_MAIN_CONTROL: begin
          rdata_reg <= {main_reg[7:2], sleep_ack_o, init_ack_o};
        end
        CMBT_OFF_BIT_TIMING_ZERO: begin
          rdata_reg <= btr0_reg;
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ****************************************************************
  // Receive pin and wake-up.
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rx_sync_reg <= 3'b111;
      rx_level_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], can_rx_i};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_level_reg <= rx_sync_reg[2];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wake_cnt_reg <= 12'h000;
    end else if (sleep_active && !rx_level_reg) begin
      if (wake_cnt_reg != CMBT_WAKE_PULSE_CYC_W) begin
        wake_cnt_reg <= wake_cnt_reg + 12'h001;
      end
    end else begin
      wake_cnt_reg <= 12'h000;
    end
  end

  always_comb begin
    wake_event = 1'b0;
    if (sleep_active && wake_enable_reg && !rx_level_reg) begin
      if (!main_reg.wake_filter_select) begin
        wake_event = 1'b1;
      end else begin
        wake_event = (wake_cnt_reg == CMBT_WAKE_PULSE_CYC_W);
      end
    end
  end

  // ****************************************************************
  // Time quantum prescaler.
  // ****************************************************************
  assign proto_tick = main_reg.protocol_clock_select ? bus_tick_i : osc_tick_i;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      tq_cnt_reg <= 6'h00;
      tq_tick_reg <= 1'b0;
    end else if (!main_reg.module_enable || init_active) begin
      tq_cnt_reg <= 6'h00;
      tq_tick_reg <= 1'b0;
    end else if (proto_tick) begin
      tq_tick_reg <= (tq_cnt_reg == btr0_reg.quantum_prescaler);
      if (tq_cnt_reg == btr0_reg.quantum_prescaler) begin
        tq_cnt_reg <= 6'h00;
      end else begin
        tq_cnt_reg <= tq_cnt_reg + 6'h01;
      end
    end else begin
      tq_tick_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs to core and bus.
  // ****************************************************************
  assign tq_tick_o = tq_tick_reg;
  assign prescale_factor_o = {1'b0, btr0_reg.quantum_prescaler} + 7'h01;
  assign resync_jump_width_o = {1'b0, btr0_reg.resync_jump_width} + 3'h1;
  assign module_enable_o = main_reg.module_enable;
  assign protocol_clock_select_o = main_reg.protocol_clock_select;
  assign init_ack_o = (state_reg == CMBT_ST_INIT);
  assign sleep_ack_o = (state_reg == CMBT_ST_SLEEP);
  assign core_abort_o = init_request_reg || !main_reg.module_enable;
  assign core_err_hold_o = main_reg.listen_only;
  assign core_tx_start_allow_o = main_reg.module_enable && !main_reg.listen_only &&
    (state_reg == CMBT_ST_RUN) && !init_request_reg;
  assign core_busoff_auto_o = !main_reg.busoff_recovery_select;
  assign core_busoff_recover_o = main_reg.busoff_recovery_select && core_busoff_i &&
    recover_req_reg;
  assign core_rx_bit_o = main_reg.internal_loopback ? core_tx_bit_i : rx_level_reg;
  assign can_tx_o = core_tx_bit_i || core_abort_o || main_reg.listen_only ||
    main_reg.internal_loopback || (state_reg != CMBT_ST_RUN);

endmodule

// file: sim/cmbt_bus_node.sv
`timescale 1ns/1ps
module cmbt_bus_node (
  // Bus pins.
  input wire logic tx_i,
  output logic rx_o,
  // Far node drives dominant.
  input wire logic dominant_i
);
  // Wired-AND bus with a recessive pull-up.
  assign rx_o = tx_i & ~dominant_i;
endmodule

// file: sim/cmbt_ctrl_sva.sv
`timescale 1ns/1ps
module cmbt_ctrl_sva (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register port.
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Core and pins.
  input wire logic core_busoff_i, core_abort_o, core_tx_start_allow_o, core_err_hold_o,
  input wire logic core_busoff_auto_o, core_busoff_recover_o, module_enable_o, tq_tick_o,
  input wire logic init_ack_o, sleep_ack_o, can_tx_o,
  input wire logic [2:0] resync_jump_width_o,
  input wire logic [6:0] prescale_factor_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_rd; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside answer");
  property p_ack; $rose(init_ack_o) |-> $past(core_abort_o); endproperty
  a_ack: assert property (p_ack) else $error("init ack without abort");
  property p_en;
    !module_enable_o |-> core_abort_o && can_tx_o && !core_tx_start_allow_o;
  endproperty
  a_en: assert property (p_en) else $error("disabled module not held");
  property p_quiet; init_ack_o || sleep_ack_o || core_err_hold_o |-> can_tx_o; endproperty
  a_quiet: assert property (p_quiet) else $error("pin driven dominant");
  property p_listen; core_err_hold_o |-> !core_tx_start_allow_o; endproperty
  a_listen: assert property (p_listen) else $error("start in listen");
  property p_range;
    resync_jump_width_o inside {[1:4]} && prescale_factor_o inside {[1:64]};
  endproperty
  a_range: assert property (p_range) else $error("timing out of range");
  property p_excl; !(init_ack_o && sleep_ack_o); endproperty
  a_excl: assert property (p_excl) else $error("both acks set");
  property p_rec; core_busoff_recover_o |-> core_busoff_i && !core_busoff_auto_o; endproperty
  a_rec: assert property (p_rec) else $error("bad recovery pulse");
  property p_tq; tq_tick_o && prescale_factor_o > 7'h01 |=> !tq_tick_o; endproperty
  a_tq: assert property (p_tq) else $error("quantum ticks too close");
  c_init: cover property ($rose(init_ack_o));
  c_sleep: cover property ($rose(sleep_ack_o));
  c_wake: cover property ($fell(sleep_ack_o));
  c_tq: cover property (tq_tick_o);
endmodule
bind cmbt_ctrl cmbt_ctrl_sva u_sva (.ref_clk_i, .resetn_i, .reg_rd_i, .reg_rdata_o,
  .core_busoff_i, .core_abort_o, .core_tx_start_allow_o, .core_err_hold_o,
  .core_busoff_auto_o, .core_busoff_recover_o, .module_enable_o, .tq_tick_o,
  .init_ack_o, .sleep_ack_o, .can_tx_o, .resync_jump_width_o, .prescale_factor_o);

// file: sim/cmbt_ctrl_tb.sv
`timescale 1ns/1ps
module cmbt_ctrl_tb;
  import cmbt_pkg::*;
  logic ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, special_mode_i, osc_tick_i, bus_tick_i;
  logic core_tx_bit_i, core_rx_busy_i, core_tx_pending_i, core_busoff_i, can_rx_i, dom;
  logic core_rx_bit_o, core_abort_o, core_tx_start_allow_o, core_err_hold_o, tq_tick_o;
  logic core_busoff_auto_o, core_busoff_recover_o, module_enable_o, protocol_clock_select_o;
  logic init_ack_o, sleep_ack_o, can_tx_o;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [2:0] resync_jump_width_o;
  logic [6:0] prescale_factor_o;
  int failures, num_checks;
  cmbt_ctrl dut (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .special_mode_i, .osc_tick_i, .bus_tick_i, .core_tx_bit_i, .core_rx_busy_i,
    .core_tx_pending_i, .core_busoff_i, .core_rx_bit_o, .core_abort_o, .core_tx_start_allow_o,
    .core_err_hold_o, .core_busoff_auto_o, .core_busoff_recover_o, .module_enable_o,
    .protocol_clock_select_o, .tq_tick_o, .resync_jump_width_o, .prescale_factor_o,
    .init_ack_o, .sleep_ack_o, .can_rx_i, .can_tx_o);
  cmbt_bus_node node (.tx_i(can_tx_o), .rx_o(can_rx_i), .dominant_i(dom));
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("rdata", e, reg_rdata_o);
  endtask
  task automatic wait_for(input bit slp, input logic v);
    int n;
    for (n = 0; n < 20; n++) begin
      if ((slp ? sleep_ack_o : init_ack_o) === v) break;
      @(posedge ref_clk_i);
      #1;
    end
    if (n == 20) begin
      failures++;
      $display("[ERR] ack expected %h seen %h", v, ~v);
      results();
    end
  endtask
  task automatic t_lock;
    rd(CMBT_OFF_MAIN_CONTROL, CMBT_MAIN_RESET);
    wr(CMBT_OFF_MAIN_CONTROL, 8'hFF);
    rd(CMBT_OFF_MAIN_CONTROL, CMBT_MAIN_RESET);
    wr(CMBT_OFF_BIT_TIMING_ZERO, 8'hC3);
    rd(CMBT_OFF_BIT_TIMING_ZERO, CMBT_BTR0_RESET);
    rd(4'hF, 8'h00);
  endtask
  task automatic t_init;
    wr(CMBT_OFF_MODE_CONTROL, 8'h01);
    wait_for(1'b0, 1'b1);
    chk("tx", 8'h01, can_tx_o);
    for (int i = 0; i < 4; i++) begin
      wr(CMBT_OFF_BIT_TIMING_ZERO, {i[1:0], 6'h3F});
      chk("sjw", 8'(i + 1), resync_jump_width_o);
      chk("psc", 8'h40, prescale_factor_o);
    end
    wr(CMBT_OFF_BIT_TIMING_ZERO, 8'h02);
    chk("psc", 8'h03, prescale_factor_o);
    rd(CMBT_OFF_BIT_TIMING_ZERO, 8'h02);
    wr(CMBT_OFF_MAIN_CONTROL, 8'hFF);
    rd(CMBT_OFF_MAIN_CONTROL, 8'hFD);
    chk("ctl", 8'h0E, {module_enable_o, protocol_clock_select_o, core_err_hold_o,
      core_busoff_auto_o});
    @(posedge ref_clk_i);
    core_tx_bit_i <= 1'b0;
    #1 chk("loop", 8'h00, core_rx_bit_o);
    wr(CMBT_OFF_MAIN_CONTROL, 8'h00);
    rd(CMBT_OFF_MAIN_CONTROL, 8'h81);
    special_mode_i <= 1'b1;
    wr(CMBT_OFF_MAIN_CONTROL, 8'h00);
    rd(CMBT_OFF_MAIN_CONTROL, 8'h01);
    wr(CMBT_OFF_MAIN_CONTROL, 8'h80);
    special_mode_i <= 1'b0;
    core_tx_bit_i <= 1'b1;
    wr(CMBT_OFF_MODE_CONTROL, 8'h00);
    wait_for(1'b0, 1'b0);
    chk("run", 8'h03, {core_abort_o, core_tx_start_allow_o, core_busoff_auto_o});
    wr(CMBT_OFF_BIT_TIMING_ZERO, 8'hFF);
    rd(CMBT_OFF_BIT_TIMING_ZERO, 8'h02);
  endtask
  task automatic t_tq;
    int n;
    @(posedge ref_clk_i);
    bus_tick_i <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge ref_clk_i);
      #1 n += tq_tick_o;
    end
    chk("tq_bus", 8'h00, 8'(n));
    bus_tick_i <= 1'b0;
    osc_tick_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    n = 0;
    repeat (12) begin
      @(posedge ref_clk_i);
      #1 n += tq_tick_o;
    end
    chk("tq_osc", 8'h04, 8'(n));
  endtask
  task automatic t_sleep;
    core_rx_busy_i <= 1'b1;
    wr(CMBT_OFF_MODE_CONTROL, 8'h06);
    repeat (5) @(posedge ref_clk_i);
    #1 chk("slp", 8'h00, sleep_ack_o);
    core_rx_busy_i <= 1'b0;
    wait_for(1'b1, 1'b1);
    dom <= 1'b1;
    wait_for(1'b1, 1'b0);
    dom <= 1'b0;
    rd(CMBT_OFF_MODE_CONTROL, 8'h04);
    wr(CMBT_OFF_MODE_CONTROL, 8'h06);
    wait_for(1'b1, 1'b1);
    wr(CMBT_OFF_MODE_CONTROL, 8'h04);
    wait_for(1'b1, 1'b0);
  endtask
  task automatic t_filt;
    wr(CMBT_OFF_MODE_CONTROL, 8'h01);
    wait_for(1'b0, 1'b1);
    wr(CMBT_OFF_MAIN_CONTROL, 8'h0C);
    rd(CMBT_OFF_MAIN_CONTROL, 8'h8D);
    wr(CMBT_OFF_MODE_CONTROL, 8'h00);
    wait_for(1'b0, 1'b0);
    core_busoff_i <= 1'b1;
    wr(CMBT_OFF_MODE_CONTROL, 8'h08);
    chk("rec", 8'h01, core_busoff_recover_o);
    @(posedge ref_clk_i);
    #1 chk("rec_end", 8'h00, core_busoff_recover_o);
    chk("auto", 8'h00, core_busoff_auto_o);
    core_busoff_i <= 1'b0;
    wr(CMBT_OFF_MODE_CONTROL, 8'h06);
    wait_for(1'b1, 1'b1);
    dom <= 1'b1;
    repeat (100) @(posedge ref_clk_i);
    dom <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1 chk("short", 8'h01, sleep_ack_o);
    dom <= 1'b1;
    repeat (CMBT_WAKE_PULSE_CYC) @(posedge ref_clk_i);
    #1 chk("filt", 8'h01, sleep_ack_o);
    wait_for(1'b1, 1'b0);
    dom <= 1'b0;
    rd(CMBT_OFF_MODE_CONTROL, 8'h04);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, special_mode_i, osc_tick_i, bus_tick_i, dom} = '0;
    {core_rx_busy_i, core_tx_pending_i, core_busoff_i, reg_addr_i, reg_wdata_i} = '0;
    core_tx_bit_i = 1'b1;
    failures = 0;
    num_checks = 0;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_lock();
    t_init();
    t_tq();
    t_sleep();
    t_filt();
    results();
  end
endmodule
